/* File: hdl/osc_pkg.sv */
// constants, enumerations and carriers of the operand shifter carry unit
package osc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned OSC_DW  = 32;
  localparam int unsigned OSC_CW  = 8;

  // ----------------------------------------------------------------
  // encoded immediate layout
  // ----------------------------------------------------------------
  localparam int unsigned OSC_IMM_ROT_HI  = 11;
  localparam int unsigned OSC_IMM_ROT_LO  = 7;
  localparam int unsigned OSC_IMM_PAT_HI  = 9;
  localparam int unsigned OSC_IMM_PAT_LO  = 8;
  localparam logic [1:0]  OSC_PAT_PLAIN   = 2'h0;
  localparam logic [1:0]  OSC_PAT_LOW2    = 2'h1;
  localparam logic [1:0]  OSC_PAT_HIGH2   = 2'h2;
  localparam logic [1:0]  OSC_PAT_ALL4    = 2'h3;

  // ----------------------------------------------------------------
  // shift encodings and limits
  // ----------------------------------------------------------------
  localparam logic [1:0]  OSC_SC_LEFT     = 2'h0;
  localparam logic [1:0]  OSC_SC_RIGHT    = 2'h1;
  localparam logic [1:0]  OSC_SC_ARITH    = 2'h2;
  localparam logic [1:0]  OSC_SC_ROT      = 2'h3;
  localparam logic [7:0]  OSC_FULL_SHIFT  = 8'h20;

  // ----------------------------------------------------------------
  // reset values and counter saturation limit
  // ----------------------------------------------------------------
  localparam logic        OSC_CARRY_RST   = 1'b0;
  localparam logic [7:0]  OSC_CNT_RST     = 8'h00;
  localparam logic [7:0]  OSC_CNT_MAX     = 8'hff;

  typedef enum logic [2:0] {
    OSC_SH_LEFT  = 3'h0,
    OSC_SH_RIGHT = 3'h1,
    OSC_SH_ARITH = 3'h2,
    OSC_SH_ROT   = 3'h3,
    OSC_SH_ROTX  = 3'h4
  } osc_shift_type;

  typedef enum logic [2:0] {
    OSC_BYTE  = 3'h0,
    OSC_HALF  = 3'h1,
    OSC_WORD  = 3'h2,
    OSC_DUAL  = 3'h3,
    OSC_MULTI = 3'h4
  } osc_size_type;

  typedef struct packed {
    osc_shift_type stype;
    logic [7:0]    amount;
  } osc_shift_type_amt_type;

  typedef struct packed {
    logic        valid;
    logic        use_imm;
    logic [11:0] imm12;
    logic [31:0] src;
    logic        by_reg;
    logic [1:0]  shift_code;
    logic [4:0]  imm5;
    logic [7:0]  amount_reg;
    logic        set_flags;
    logic        logical_op;
  } osc_req_type;

  typedef struct packed {
    logic         valid;
    logic [31:0]  addr;
    osc_size_type size;
    logic         single_ls;
  } osc_mem_type;

  typedef struct packed {
    logic        valid;
    logic [31:0] operand;
    logic        carry_upd;
  } osc_res_type;

  typedef struct packed {
    logic valid;
    logic aligned;
    logic fault;
    logic slow;
  } osc_mres_type;

  typedef struct packed {
    osc_res_type  res;
    osc_mres_type mres;
    logic         carry_flag;
    logic         pc_bad;
    logic [7:0]   fault_cnt;
    logic [7:0]   slow_cnt;
  } osc_state_type;

endpackage

/* File: hdl/osc_barrel.sv */
// barrel shifter with shifter carry-out
`timescale 1ns/10ps
module osc_barrel (
  // operand
  input  wire logic [31:0]          i_src,
  input  wire osc_pkg::osc_shift_type i_stype,
  input  wire logic [7:0]           i_amount,
  input  wire logic                 i_carry_in,
  // result
  output logic [31:0]               o_result,
  output logic                      o_carry_out,
  output logic                      o_shifted
);

  logic [4:0]  m;
  logic [63:0] wide;
  logic [32:0] ext;

  always_comb begin
    m           = i_amount[4:0];
    wide        = 64'h0;
    ext         = 33'h0;
    o_result    = i_src;
    o_carry_out = i_carry_in;
    case (i_stype)
      osc_pkg::OSC_SH_LEFT: begin
        wide = {32'h0, i_src} << m;
        if (i_amount == 8'h00) begin
          o_result = i_src;
        end else if (i_amount < osc_pkg::OSC_FULL_SHIFT) begin
          o_result    = wide[31:0];
          o_carry_out = wide[32];
        end else if (i_amount == osc_pkg::OSC_FULL_SHIFT) begin
          o_result    = 32'h0;
          o_carry_out = i_src[0];
        end else begin
          o_result    = 32'h0;
          o_carry_out = 1'b0;
        end
      end
      osc_pkg::OSC_SH_RIGHT: begin
        ext = {i_src, 1'b0} >> m;
        if (i_amount == 8'h00) begin
          o_result = i_src;
        end else if (i_amount < osc_pkg::OSC_FULL_SHIFT) begin
          o_result    = ext[32:1];
          o_carry_out = ext[0];
        end else if (i_amount == osc_pkg::OSC_FULL_SHIFT) begin
          o_result    = 32'h0;
          o_carry_out = i_src[31];
        end else begin
          o_result    = 32'h0;
          o_carry_out = 1'b0;
        end
      end
      osc_pkg::OSC_SH_ARITH: begin
        ext = 33'($signed({i_src, 1'b0}) >>> m);
        if (i_amount == 8'h00) begin
          o_result = i_src;
        end else if (i_amount < osc_pkg::OSC_FULL_SHIFT) begin
          o_result    = ext[32:1];
          o_carry_out = ext[0];
        end else begin
          o_result    = {32{i_src[31]}};
          o_carry_out = i_src[31];
        end
      end
      osc_pkg::OSC_SH_ROT: begin
        wide = {i_src, i_src} >> m;
        if (i_amount == 8'h00) begin
          o_result = i_src;
        end else begin
          o_result    = wide[31:0];
          o_carry_out = wide[31];
        end
      end
      osc_pkg::OSC_SH_ROTX: begin
        o_result    = {i_carry_in, i_src[31:1]};
        o_carry_out = i_src[0];
      end
      default: begin
        o_result = i_src;
      end
    endcase
    o_shifted = (i_stype == osc_pkg::OSC_SH_ROTX) || (i_amount != 8'h00);
  end

endmodule

/* File: hdl/osc_unit.sv */
// operand shifter carry unit: second operand, shifter carry, alignment check
`timescale 1ns/10ps
module osc_unit (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  // operand request
  input  wire osc_pkg::osc_req_type  i_op,
  // carry written by other datapath parts
  input  wire logic                  i_carry_wr,
  input  wire logic                  i_carry_val,
  // memory access check
  input  wire osc_pkg::osc_mem_type  i_mem,
  input  wire logic                  i_unaligned_trap_enable,
  // program counter load check
  input  wire logic                  i_pc_load_valid,
  input  wire logic [31:0]           i_pc_load_addr,
  // operand result
  output osc_pkg::osc_res_type       o_res,
  output logic                       o_carry_flag,
  // memory check result
  output osc_pkg::osc_mres_type      o_mres,
  output logic                       o_pc_load_bad,
  // status counters
  output logic [7:0]                 o_fault_count,
  output logic [7:0]                 o_unaligned_count
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // expand the 12-bit encoded immediate
  function automatic logic [31:0] expand_imm(input logic [11:0] imm);
    logic [7:0]  xy;
    logic [4:0]  rot;
    logic [63:0] w;
    xy  = imm[7:0];
    rot = imm[osc_pkg::OSC_IMM_ROT_HI:osc_pkg::OSC_IMM_ROT_LO];
    w   = 64'h0;
    if (imm[11:10] == 2'h0) begin
      case (imm[osc_pkg::OSC_IMM_PAT_HI:osc_pkg::OSC_IMM_PAT_LO])
        osc_pkg::OSC_PAT_PLAIN: expand_imm = {24'h0, xy};
        osc_pkg::OSC_PAT_LOW2:  expand_imm = {8'h0, xy, 8'h0, xy};
        osc_pkg::OSC_PAT_HIGH2: expand_imm = {xy, 8'h0, xy, 8'h0};
        osc_pkg::OSC_PAT_ALL4:  expand_imm = {xy, xy, xy, xy};
        default:                expand_imm = {24'h0, xy};
      endcase
    end else begin
      // byte of a one above imm[6:0], zero-extended and rotated right by the 5-bit count
      w          = {24'h0, 1'b1, imm[6:0], 24'h0, 1'b1, imm[6:0]} >> rot;
      expand_imm = w[31:0];
    end
  endfunction

  // the shifted-byte form is the only one that yields a carry
  function automatic logic imm_is_shifted(input logic [11:0] imm);
    imm_is_shifted = (imm[11:10] != 2'h0);
  endfunction

  // decode the shift field of a register operand
  function automatic osc_pkg::osc_shift_type_amt_type decode_shift(
    input logic       by_reg,
    input logic [1:0] code,
    input logic [4:0] imm5,
    input logic [7:0] amt_reg
  );
    osc_pkg::osc_shift_type_amt_type d;
    d.stype  = osc_pkg::OSC_SH_LEFT;
    d.amount = {3'h0, imm5};
    case (code)
      osc_pkg::OSC_SC_LEFT:  d.stype = osc_pkg::OSC_SH_LEFT;
      osc_pkg::OSC_SC_RIGHT: d.stype = osc_pkg::OSC_SH_RIGHT;
      osc_pkg::OSC_SC_ARITH: d.stype = osc_pkg::OSC_SH_ARITH;
      osc_pkg::OSC_SC_ROT:   d.stype = osc_pkg::OSC_SH_ROT;
      default:               d.stype = osc_pkg::OSC_SH_LEFT;
    endcase
    if (by_reg) begin
      d.amount = amt_reg;
    end else if (imm5 == 5'h00) begin
      case (code)
        osc_pkg::OSC_SC_RIGHT: d.amount = osc_pkg::OSC_FULL_SHIFT;
        osc_pkg::OSC_SC_ARITH: d.amount = osc_pkg::OSC_FULL_SHIFT;
        osc_pkg::OSC_SC_ROT:   d.stype  = osc_pkg::OSC_SH_ROTX;
        default:               d.amount = 8'h00;
      endcase
    end
    decode_shift = d;
  endfunction

  // alignment of an access
  function automatic logic is_aligned(
    input osc_pkg::osc_size_type sz,
    input logic [1:0]            a
  );
    case (sz)
      osc_pkg::OSC_BYTE:  is_aligned = 1'b1;
      osc_pkg::OSC_HALF:  is_aligned = (a[0] == 1'b0);
      osc_pkg::OSC_WORD:  is_aligned = (a == 2'h0);
      osc_pkg::OSC_DUAL:  is_aligned = (a == 2'h0);
      osc_pkg::OSC_MULTI: is_aligned = (a == 2'h0);
      default:            is_aligned = (a == 2'h0);
    endcase
  endfunction

  // only single word and halfword transfers may run unaligned
  function automatic logic may_unalign(
    input osc_pkg::osc_size_type sz,
    input logic                  single_ls
  );
    may_unalign = single_ls &&
                  ((sz == osc_pkg::OSC_WORD) || (sz == osc_pkg::OSC_HALF));
  endfunction

  // saturating event counter
  function automatic logic [7:0] sat_inc(input logic [7:0] c, input logic ev);
    if (ev && (c != osc_pkg::OSC_CNT_MAX)) begin
      sat_inc = c + 8'h01;
    end else begin
      sat_inc = c;
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  osc_pkg::osc_state_type state_ff;
  osc_pkg::osc_state_type nxt_state;

  // ----------------------------------------------------------------
  // shifter
  // ----------------------------------------------------------------
  osc_pkg::osc_shift_type_amt_type sh_dec;
  logic [31:0]                     sh_result;
  logic                            sh_carry;
  logic                            sh_shifted;

  assign sh_dec = decode_shift(i_op.by_reg, i_op.shift_code, i_op.imm5, i_op.amount_reg);

  osc_barrel u_barrel (
    .i_src       (i_op.src),
    .i_stype     (sh_dec.stype),
    .i_amount    (sh_dec.amount),
    .i_carry_in  (state_ff.carry_flag),
    .o_result    (sh_result),
    .o_carry_out (sh_carry),
    .o_shifted   (sh_shifted)
  );

  // ----------------------------------------------------------------
  // operand and carry decision
  // ----------------------------------------------------------------
  logic [31:0] imm_val;
  logic [31:0] operand;
  logic        upd_carry;
  logic        new_carry;

  always_comb begin
    imm_val   = expand_imm(i_op.imm12);
    upd_carry = 1'b0;
    new_carry = state_ff.carry_flag;
    if (i_op.use_imm) begin
      operand = imm_val;
      if (i_op.set_flags && i_op.logical_op && imm_is_shifted(i_op.imm12)) begin
        upd_carry = 1'b1;
        new_carry = imm_val[31];
      end
    end else begin
      operand = sh_result;
      if (i_op.set_flags && i_op.logical_op && sh_shifted) begin
        upd_carry = 1'b1;
        new_carry = sh_carry;
      end
    end
  end

  // ----------------------------------------------------------------
  // alignment check
  // ----------------------------------------------------------------
  logic m_aligned;
  logic m_fault;
  logic m_slow;

  always_comb begin
    m_aligned = is_aligned(i_mem.size, i_mem.addr[1:0]);
    m_fault   = 1'b0;
    m_slow    = 1'b0;
    if (i_mem.valid && !m_aligned) begin
      if (i_unaligned_trap_enable) begin
        m_fault = 1'b1;
      end else if (!may_unalign(i_mem.size, i_mem.single_ls)) begin
        m_fault = 1'b1;
      end else begin
        m_slow = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;

    nxt_state.res.valid     = i_op.valid;
    nxt_state.res.carry_upd = i_op.valid && upd_carry;
    if (i_op.valid) begin
      nxt_state.res.operand = operand;
    end

    // shifter carry wins over a write from another datapath part
    if (i_op.valid && upd_carry) begin
      nxt_state.carry_flag = new_carry;
    end else if (i_carry_wr) begin
      nxt_state.carry_flag = i_carry_val;
    end

    nxt_state.mres.valid = i_mem.valid;
    if (i_mem.valid) begin
      nxt_state.mres.aligned = m_aligned;
    end
    nxt_state.mres.fault = m_fault;
    nxt_state.mres.slow  = m_slow;

    nxt_state.pc_bad = i_pc_load_valid && !i_pc_load_addr[0];

    nxt_state.fault_cnt = sat_inc(state_ff.fault_cnt, m_fault);
    nxt_state.slow_cnt  = sat_inc(state_ff.slow_cnt, m_slow);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_ff.res.valid     <= 1'b0;
      state_ff.res.operand   <= 32'h0;
      state_ff.res.carry_upd <= 1'b0;
      state_ff.mres.valid    <= 1'b0;
      state_ff.mres.aligned  <= 1'b1;
      state_ff.mres.fault    <= 1'b0;
      state_ff.mres.slow     <= 1'b0;
      state_ff.carry_flag    <= osc_pkg::OSC_CARRY_RST;
      state_ff.pc_bad        <= 1'b0;
      state_ff.fault_cnt     <= osc_pkg::OSC_CNT_RST;
      state_ff.slow_cnt      <= osc_pkg::OSC_CNT_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_res             = state_ff.res;
  assign o_carry_flag      = state_ff.carry_flag;
  assign o_mres            = state_ff.mres;
  assign o_pc_load_bad     = state_ff.pc_bad;
  assign o_fault_count     = state_ff.fault_cnt;
  assign o_unaligned_count = state_ff.slow_cnt;

endmodule

/* File: sim/osc_unit_chk.sv */
// concurrent checks of the operand shifter carry unit ports
`timescale 1ns/10ps
module osc_unit_chk (
  // clock and reset
  input wire logic                  i_clk,
  input wire logic                  i_srst,
  // requests
  input wire osc_pkg::osc_req_type  i_op,
  input wire logic                  i_carry_wr,
  input wire osc_pkg::osc_mem_type  i_mem,
  input wire logic                  i_unaligned_trap_enable,
  input wire logic                  i_pc_load_valid,
  input wire logic [31:0]           i_pc_load_addr,
  // results
  input wire osc_pkg::osc_res_type  o_res,
  input wire logic                  o_carry_flag,
  input wire osc_pkg::osc_mres_type o_mres,
  input wire logic                  o_pc_load_bad
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic unal;
  logic sh_req;
  assign unal = (i_mem.size == osc_pkg::OSC_HALF) ? i_mem.addr[0] :
                ((i_mem.size != osc_pkg::OSC_BYTE) && (i_mem.addr[1:0] != 2'h0));
  assign sh_req = i_op.valid && !i_op.use_imm && !i_op.by_reg;

  sequence s_rotx_req;
    sh_req && (i_op.shift_code == osc_pkg::OSC_SC_ROT) && (i_op.imm5 == 5'h00);
  endsequence
  sequence s_trap_req;
    i_mem.valid && i_unaligned_trap_enable && unal;
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_zero_shift_pass: assert property (
    sh_req && (i_op.shift_code == osc_pkg::OSC_SC_LEFT) && (i_op.imm5 == 5'h00)
    |=> o_res.valid && (o_res.operand == $past(i_op.src)) && !o_res.carry_upd)
    else $error("zero shift did not pass the source");
  a_right_full_zero: assert property (
    sh_req && (i_op.shift_code == osc_pkg::OSC_SC_RIGHT) && (i_op.imm5 == 5'h00)
    |=> o_res.valid && (o_res.operand == 32'h0000_0000))
    else $error("logical right shift of 32 not zero");
  a_arith_full_sign: assert property (
    sh_req && (i_op.shift_code == osc_pkg::OSC_SC_ARITH) && (i_op.imm5 == 5'h00)
    |=> o_res.operand == {32{$past(i_op.src[31])}})
    else $error("arithmetic shift of 32 not all sign");
  a_rotx_insert: assert property (
    s_rotx_req |=> o_res.operand == {$past(o_carry_flag), $past(i_op.src[31:1])})
    else $error("rotate extend result wrong");
  a_no_flag_keep: assert property (
    i_op.valid && !(i_op.set_flags && i_op.logical_op) && !i_carry_wr
    |=> !o_res.carry_upd && $stable(o_carry_flag))
    else $error("carry changed without flag request");
  a_imm_carry_load: assert property (
    i_op.valid && i_op.use_imm && (i_op.imm12[11:10] != 2'h0) && i_op.set_flags
    && i_op.logical_op |=> o_res.carry_upd && (o_carry_flag == o_res.operand[31]))
    else $error("shifted immediate did not load carry");
  a_imm_pat_keep: assert property (
    i_op.valid && i_op.use_imm && (i_op.imm12[11:10] == 2'h0) && !i_carry_wr
    |=> !o_res.carry_upd && $stable(o_carry_flag))
    else $error("pattern immediate changed carry");
  a_trap_all: assert property (
    s_trap_req |=> o_mres.valid && o_mres.fault && !o_mres.aligned)
    else $error("trapped unaligned access without fault");
  a_byte_aligned: assert property (
    i_mem.valid && (i_mem.size == osc_pkg::OSC_BYTE)
    |=> o_mres.aligned && !o_mres.fault && !o_mres.slow)
    else $error("byte access not aligned");
  a_single_slow: assert property (
    i_mem.valid && !i_unaligned_trap_enable && i_mem.single_ls && unal
    && ((i_mem.size == osc_pkg::OSC_HALF) || (i_mem.size == osc_pkg::OSC_WORD))
    |=> o_mres.slow && !o_mres.fault)
    else $error("permitted unaligned access faulted");
  a_pc_bit0: assert property (
    i_pc_load_valid && !i_pc_load_addr[0] |=> o_pc_load_bad)
    else $error("even program counter load not flagged");
endmodule

bind osc_unit osc_unit_chk u_chk (
  .i_clk(i_clk), .i_srst(i_srst), .i_op(i_op), .i_carry_wr(i_carry_wr), .i_mem(i_mem),
  .i_unaligned_trap_enable(i_unaligned_trap_enable), .i_pc_load_valid(i_pc_load_valid),
  .i_pc_load_addr(i_pc_load_addr), .o_res(o_res), .o_carry_flag(o_carry_flag),
  .o_mres(o_mres), .o_pc_load_bad(o_pc_load_bad)
);

/* File: sim/tb.sv */
// self-checking testbench of the operand shifter carry unit
`timescale 1ns/10ps
module tb;
  logic                  i_clk;
  logic                  i_srst;
  osc_pkg::osc_req_type  i_op;
  logic                  i_carry_wr;
  logic                  i_carry_val;
  osc_pkg::osc_mem_type  i_mem;
  logic                  i_unaligned_trap_enable;
  logic                  i_pc_load_valid;
  logic [31:0]           i_pc_load_addr;
  osc_pkg::osc_res_type  o_res;
  logic                  o_carry_flag;
  osc_pkg::osc_mres_type o_mres;
  logic                  o_pc_load_bad;
  logic [7:0]            o_fault_count;
  logic [7:0]            o_unaligned_count;
  int                    num_errors = 0;
  int                    checks = 0;
  logic [31:0]           pv [4] = '{32'h0000_00ab, 32'h00ab_00ab, 32'hab00_ab00, 32'habab_abab};

  osc_unit DUT (
    .i_clk(i_clk), .i_srst(i_srst), .i_op(i_op), .i_carry_wr(i_carry_wr),
    .i_carry_val(i_carry_val), .i_mem(i_mem), .i_unaligned_trap_enable(i_unaligned_trap_enable),
    .i_pc_load_valid(i_pc_load_valid), .i_pc_load_addr(i_pc_load_addr), .o_res(o_res),
    .o_carry_flag(o_carry_flag), .o_mres(o_mres), .o_pc_load_bad(o_pc_load_bad),
    .o_fault_count(o_fault_count), .o_unaligned_count(o_unaligned_count)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic osc_pkg::osc_req_type sh(input logic [31:0] s, input logic [1:0] c,
      input logic by, input logic [7:0] n, input logic sf, input logic lo);
    osc_pkg::osc_req_type r;
    r = '0;
    r.valid = 1'b1;
    r.src = s;
    r.shift_code = c;
    r.by_reg = by;
    r.imm5 = n[4:0];
    r.amount_reg = n;
    r.set_flags = sf;
    r.logical_op = lo;
    return r;
  endfunction

  function automatic osc_pkg::osc_req_type im(input logic [11:0] v);
    osc_pkg::osc_req_type r;
    r = sh(32'h0, 2'h0, 1'b0, 8'h00, 1'b1, 1'b1);
    r.use_imm = 1'b1;
    r.imm12 = v;
    return r;
  endfunction

  task automatic op(input osc_pkg::osc_req_type r, input logic [31:0] ev, input logic eu,
      input logic ec);
    @(negedge i_clk);
    i_op = r;
    @(negedge i_clk);
    i_op.valid = 1'b0;
    chk("res_valid", o_res.valid, 1'b1);
    chk("operand", o_res.operand, ev);
    chk("carry_upd", o_res.carry_upd, eu);
    chk("carry_flag", o_carry_flag, ec);
  endtask

  task automatic mem(input logic [31:0] a, input osc_pkg::osc_size_type sz, input logic sl,
      input logic tr, input logic ea, input logic ef, input logic es);
    @(negedge i_clk);
    i_mem = '{valid: 1'b1, addr: a, size: sz, single_ls: sl};
    i_unaligned_trap_enable = tr;
    @(negedge i_clk);
    i_mem.valid = 1'b0;
    chk("mres_valid", o_mres.valid, 1'b1);
    chk("aligned", o_mres.aligned, ea);
    chk("fault", o_mres.fault, ef);
    chk("slow", o_mres.slow, es);
  endtask

  task automatic pc(input logic [31:0] a, input logic eb);
    @(negedge i_clk);
    i_pc_load_valid = 1'b1;
    i_pc_load_addr = a;
    @(negedge i_clk);
    i_pc_load_valid = 1'b0;
    chk("pc_load_bad", o_pc_load_bad, eb);
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial begin
    repeat (2000) @(posedge i_clk);
    num_errors++;
    test_done();
  end

  initial begin
    i_srst = 1'b1;
    i_op = '0;
    i_mem = '0;
    i_carry_wr = 1'b0;
    i_carry_val = 1'b0;
    i_unaligned_trap_enable = 1'b0;
    i_pc_load_valid = 1'b0;
    i_pc_load_addr = 32'h0;
    repeat (5) @(negedge i_clk);
    i_srst = 1'b0;
    chk("carry_rst", o_carry_flag, 1'b0);
    chk("aligned_rst", o_mres.aligned, 1'b1);
    chk("fault_cnt_rst", o_fault_count, 8'h00);
    i_carry_wr = 1'b1;
    i_carry_val = 1'b1;
    @(negedge i_clk);
    i_carry_wr = 1'b0;
    chk("carry_wr", o_carry_flag, 1'b1);
    op(sh(32'h1234_5678, 2'h0, 1'b0, 8'h00, 1'b1, 1'b1), 32'h1234_5678, 1'b0, 1'b1);
    op(sh(32'h0800_0003, 2'h0, 1'b0, 8'h04, 1'b1, 1'b1), 32'h8000_0030, 1'b1, 1'b0);
    op(sh(32'h8000_0001, 2'h1, 1'b0, 8'h00, 1'b1, 1'b1), 32'h0, 1'b1, 1'b1);
    op(sh(32'h8000_0001, 2'h1, 1'b1, 8'h21, 1'b1, 1'b1), 32'h0, 1'b1, 1'b0);
    op(sh(32'h0000_0001, 2'h0, 1'b1, 8'h20, 1'b1, 1'b1), 32'h0, 1'b1, 1'b1);
    op(sh(32'h8000_0010, 2'h2, 1'b0, 8'h03, 1'b1, 1'b1), 32'hf000_0002, 1'b1, 1'b0);
    op(sh(32'h8000_0000, 2'h2, 1'b1, 8'h28, 1'b1, 1'b1), 32'hffff_ffff, 1'b1, 1'b1);
    op(sh(32'h0000_0016, 2'h3, 1'b0, 8'h04, 1'b1, 1'b1), 32'h6000_0001, 1'b1, 1'b0);
    op(sh(32'h8000_0001, 2'h3, 1'b1, 8'h20, 1'b1, 1'b1), 32'h8000_0001, 1'b1, 1'b1);
    op(sh(32'h0000_0016, 2'h3, 1'b1, 8'h24, 1'b1, 1'b1), 32'h6000_0001, 1'b1, 1'b0);
    op(sh(32'h0000_0003, 2'h3, 1'b0, 8'h00, 1'b1, 1'b1), 32'h0000_0001, 1'b1, 1'b1);
    op(sh(32'h0000_0002, 2'h3, 1'b0, 8'h00, 1'b1, 1'b1), 32'h8000_0001, 1'b1, 1'b0);
    op(sh(32'h0000_00f0, 2'h1, 1'b1, 8'h00, 1'b1, 1'b1), 32'h0000_00f0, 1'b0, 1'b0);
    op(sh(32'h0000_0001, 2'h1, 1'b0, 8'h01, 1'b0, 1'b1), 32'h0, 1'b0, 1'b0);
    op(sh(32'h0000_0001, 2'h1, 1'b0, 8'h01, 1'b1, 1'b0), 32'h0, 1'b0, 1'b0);
    op(im(12'h47f), 32'hff00_0000, 1'b1, 1'b1);
    for (int p = 0; p < 4; p++) begin
      op(im({2'h0, p[1:0], 8'hab}), pv[p], 1'b0, 1'b1);
    end
    op(im(12'h480), 32'h4000_0000, 1'b1, 1'b0);
    mem(32'h1001, osc_pkg::OSC_BYTE, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    mem(32'h1002, osc_pkg::OSC_HALF, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    mem(32'h1001, osc_pkg::OSC_HALF, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    mem(32'h1002, osc_pkg::OSC_WORD, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    mem(32'h1002, osc_pkg::OSC_WORD, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    mem(32'h1004, osc_pkg::OSC_DUAL, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    mem(32'h1006, osc_pkg::OSC_DUAL, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    mem(32'h100a, osc_pkg::OSC_MULTI, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    mem(32'h1001, osc_pkg::OSC_HALF, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    mem(32'h1004, osc_pkg::OSC_WORD, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    chk("fault_count", o_fault_count, 8'h04);
    chk("unaligned_count", o_unaligned_count, 8'h02);
    pc(32'h2000_0000, 1'b1);
    pc(32'h2000_0001, 1'b0);
    test_done();
  end
endmodule
